// ### rtl/mdss_pkg.sv
// Package of constants and types for the motor drive stop sequencer
package mdss_pkg;
   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int unsigned SPEED_W = 16;      // Speed, 0x0000..0xFFFF = 0..100 %
   localparam int unsigned CUR_W   = 16;      // Current limit width
   localparam int unsigned TIME_W  = 16;      // Times in milliseconds
   localparam int unsigned TICK_W  = 17;      // Millisecond divider width

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_MHZ    = 100;
   localparam int unsigned TICK_US    = 1000;   // Time base of one millisecond
   localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   // ------------------------------------------------------------
   // Thresholds and reset values
   // ------------------------------------------------------------
   // 0.25 % of full scale speed, 65535 * 0.0025 rounded down
   localparam logic [SPEED_W-1:0] ZERO_QUARTER_PCT = 16'h00A3;
   localparam logic [SPEED_W-1:0] SPEED_ZERO       = 16'h0000;
   localparam logic [TIME_W-1:0]  TIME_ZERO        = 16'h0000;
   localparam logic [TIME_W-1:0]  TIME_ONE         = 16'h0001;

   // ------------------------------------------------------------
   // Sequencer states, Gray along run, stop, delay, off
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF     = 3'b000,
      ST_RUN     = 3'b001,
      ST_NSTOP   = 3'b011,
      ST_CDELAY  = 3'b010,
      ST_PSTOP   = 3'b110
   } mdss_state_type;
endpackage

// ### rtl/mdss_ramp.sv
// Speed demand ramp with a per-millisecond step size
module mdss_ramp (
   input  wire logic                           ref_clk,
   input  wire logic                           rst,
   input  wire logic                           tick,
   input  wire logic                           load,
   input  wire logic [mdss_pkg::SPEED_W-1:0]   load_value,
   input  wire logic                           ramp_down,
   input  wire logic [mdss_pkg::SPEED_W-1:0]   step,
   output logic      [mdss_pkg::SPEED_W-1:0]   demand
);
   // ------------------------------------------------------------
   // Ramp register
   // ------------------------------------------------------------
   logic [mdss_pkg::SPEED_W-1:0] next_demand;

   // Step down, saturating at zero
   assign next_demand = (demand > step) ? demand - step : mdss_pkg::SPEED_ZERO;

   // Load tracks the setpoint while running, else ramp on each tick
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         demand <= mdss_pkg::SPEED_ZERO;
      end else if (load) begin
         demand <= load_value;
      end else if (ramp_down && tick) begin
         demand <= next_demand;
      end
   end
endmodule

// ### rtl/mdss_top.sv
// Stop sequencer: standstill, normal stop, contactor delay, programmed stop
//
// Operation
// - Inhibit controller when setpoint and measured speed are both zero.
// - During standstill inhibit keep contactor energized and run indicator on.
// - Removing the run input starts a normal stop.
// - Normal stop ramps speed demand to zero at the stop time rate.
// - Non-regenerative normal stop never decelerates faster than the coast rate.
// - Regenerative variant ramps full scale to zero in half the stop time.
// - Completed normal stop drops contactor and disables drive.
// - Stop-limit timer starts when the run input drops low.
// - Speed above threshold at stop-limit expiry drops contactor, disables drive.
// - Contactor held for the contactor delay after zero speed in normal stop.
// - Threshold above 0.25 % disables drive at delay start, else at its end.
// - Low delay-override input skips the contactor delay.
// - Programmed stop ramp duration comes from programmed stop time.
// - Programmed-stop timer starts when the fast stop input drops low.
// - Programmed stop drops contactor and drive at the zero-speed threshold.
// - Programmed stop over its limit time drops contactor and drive.
// - Programmed stop passes its current limit to the current loop.
// - Other active current limits take precedence over programmed limit.
module mdss_top (
   input  wire logic                           ref_clk,
   input  wire logic                           rst,
   input  wire logic                           run_input_terminal,
   input  wire logic                           delay_override_terminal,
   input  wire logic                           fast_stop_terminal,
   input  wire logic                           regen_variant,
   input  wire logic [mdss_pkg::SPEED_W-1:0]   speed_setpoint,
   input  wire logic [mdss_pkg::SPEED_W-1:0]   speed_feedback,
   input  wire logic [mdss_pkg::SPEED_W-1:0]   zero_threshold,
   input  wire logic [mdss_pkg::SPEED_W-1:0]   stop_zero_speed,
   input  wire logic [mdss_pkg::TIME_W-1:0]    stop_time_ms,
   input  wire logic [mdss_pkg::TIME_W-1:0]    stop_limit_ms,
   input  wire logic [mdss_pkg::TIME_W-1:0]    contactor_delay_ms,
   input  wire logic [mdss_pkg::TIME_W-1:0]    prog_stop_time_ms,
   input  wire logic [mdss_pkg::TIME_W-1:0]    prog_stop_limit_ms,
   input  wire logic [mdss_pkg::SPEED_W-1:0]   coast_step,
   input  wire logic [mdss_pkg::CUR_W-1:0]     prog_stop_i_limit,
   input  wire logic [mdss_pkg::CUR_W-1:0]     other_i_limit,
   input  wire logic                           other_i_limit_active,
   output logic      [mdss_pkg::SPEED_W-1:0]   speed_demand,
   output logic      [mdss_pkg::CUR_W-1:0]     current_limit,
   output logic                                current_limit_valid,
   output logic                                contactor_on,
   output logic                                drive_enable,
   output logic                                controller_inhibit,
   output logic                                run_indicator,
   output logic                                prog_stop_active
);
   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------

   // Step per millisecond so that full scale reaches zero in ms/2 milliseconds
   function automatic logic [mdss_pkg::SPEED_W-1:0] step_for(
      input logic [mdss_pkg::TIME_W-1:0] ms);
      logic [mdss_pkg::SPEED_W-1:0] q;
      q = '1;
      if (ms != mdss_pkg::TIME_ZERO) begin
         q = mdss_pkg::SPEED_W'(17'h1_FFFF / {1'b0, ms});
         if (q == mdss_pkg::SPEED_ZERO) begin
            q = 16'h0001;
         end
      end
      return q;
   endfunction

   // Millisecond counter advance, saturating at all ones
   function automatic logic [mdss_pkg::TIME_W-1:0] bump(
      input logic [mdss_pkg::TIME_W-1:0] t);
      return (t == '1) ? t : t + mdss_pkg::TIME_ONE;
   endfunction

   // ------------------------------------------------------------
   // Millisecond time base
   // ------------------------------------------------------------
   logic [mdss_pkg::TICK_W-1:0] tick_count;
   logic                        tick;

   // One-cycle enable every millisecond
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tick_count <= '0;
         tick       <= 1'b0;
      end else begin
         tick       <= (tick_count == mdss_pkg::TICK_LAST);
         tick_count <= (tick_count == mdss_pkg::TICK_LAST) ? '0 : tick_count + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Conditions
   // ------------------------------------------------------------
   mdss_pkg::mdss_state_type state;
   mdss_pkg::mdss_state_type next_state;
   logic [mdss_pkg::TIME_W-1:0] stop_timer;
   logic [mdss_pkg::TIME_W-1:0] delay_timer;
   logic                        run_in_prev;
   logic                        fast_in_prev;
   logic [mdss_pkg::SPEED_W-1:0] ramp_demand;

   wire at_zero_speed    = speed_feedback < zero_threshold;
   wire at_zero_setpoint = speed_setpoint < zero_threshold;
   wire at_standstill    = at_zero_speed && at_zero_setpoint;
   wire below_stop_zero  = speed_feedback <= stop_zero_speed;
   wire run_fall         = run_in_prev && !run_input_terminal;
   wire fast_fall        = fast_in_prev && !fast_stop_terminal;
   wire early_disable    = stop_zero_speed > mdss_pkg::ZERO_QUARTER_PCT;
   wire stop_expired     = tick && (bump(stop_timer) >= stop_limit_ms);
   wire prog_expired     = tick && (bump(stop_timer) >= prog_stop_limit_ms);
   wire delay_done       = tick && (bump(delay_timer) >= contactor_delay_ms);
   wire in_ramp          = (state == mdss_pkg::ST_NSTOP) || (state == mdss_pkg::ST_PSTOP);

   // Normal stop step: regen uses stop time, non-regen limited to coast rate
   wire [mdss_pkg::SPEED_W-1:0] nstop_step = step_for(stop_time_ms);
   wire [mdss_pkg::SPEED_W-1:0] limited_step =
      (!regen_variant && nstop_step > coast_step) ? coast_step : nstop_step;
   wire [mdss_pkg::SPEED_W-1:0] ramp_step =
      (state == mdss_pkg::ST_PSTOP) ? step_for(prog_stop_time_ms) : limited_step;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state)
         mdss_pkg::ST_OFF: begin
            if (run_input_terminal && fast_stop_terminal) begin
               next_state = mdss_pkg::ST_RUN;
            end
         end
         mdss_pkg::ST_RUN: begin
            if (!fast_stop_terminal) begin
               next_state = mdss_pkg::ST_PSTOP;
            end else if (!run_input_terminal) begin
               next_state = mdss_pkg::ST_NSTOP;
            end
         end
         mdss_pkg::ST_NSTOP: begin
            if (fast_fall || !fast_stop_terminal) begin
               next_state = mdss_pkg::ST_PSTOP;
            end else if (ramp_demand == mdss_pkg::SPEED_ZERO && below_stop_zero) begin
               // Delay skipped when the override terminal is low
               next_state = delay_override_terminal ? mdss_pkg::ST_CDELAY
                                                    : mdss_pkg::ST_OFF;
            end else if (stop_expired) begin
               next_state = mdss_pkg::ST_OFF;
            end
         end
         mdss_pkg::ST_CDELAY: begin
            if (!fast_stop_terminal) begin
               next_state = mdss_pkg::ST_PSTOP;
            end else if (delay_done || !delay_override_terminal) begin
               next_state = mdss_pkg::ST_OFF;
            end
         end
         mdss_pkg::ST_PSTOP: begin
            if (below_stop_zero || prog_expired) begin
               next_state = mdss_pkg::ST_OFF;
            end
         end
         default: next_state = mdss_pkg::ST_OFF;
      endcase
   end

   // ------------------------------------------------------------
   // State and timers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state        <= mdss_pkg::ST_OFF;
         run_in_prev  <= 1'b0;
         fast_in_prev <= 1'b0;
      end else begin
         state        <= next_state;
         run_in_prev  <= run_input_terminal;
         fast_in_prev <= fast_stop_terminal;
      end
   end

   // Stop timer restarts on entry to either stop, counts milliseconds
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stop_timer <= mdss_pkg::TIME_ZERO;
      end else if (run_fall || fast_fall || next_state != state) begin
         stop_timer <= mdss_pkg::TIME_ZERO;
      end else if (tick) begin
         stop_timer <= bump(stop_timer);
      end
   end

   // Contactor delay timer, counts only inside the delay
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         delay_timer <= mdss_pkg::TIME_ZERO;
      end else if (state != mdss_pkg::ST_CDELAY) begin
         delay_timer <= mdss_pkg::TIME_ZERO;
      end else if (tick) begin
         delay_timer <= bump(delay_timer);
      end
   end

   // ------------------------------------------------------------
   // Speed demand ramp
   // ------------------------------------------------------------
   mdss_ramp u_ramp (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .tick       (tick),
      .load       (state == mdss_pkg::ST_RUN && next_state == mdss_pkg::ST_RUN),
      .load_value (speed_setpoint),
      .ramp_down  (in_ramp),
      .step       (ramp_step),
      .demand     (ramp_demand)
   );

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   wire run_like  = (next_state == mdss_pkg::ST_RUN) || (next_state == mdss_pkg::ST_NSTOP)
                    || (next_state == mdss_pkg::ST_PSTOP);
   wire cdelay_n  = next_state == mdss_pkg::ST_CDELAY;
   wire pstop_n   = next_state == mdss_pkg::ST_PSTOP;
   wire next_contactor = run_like || cdelay_n;
   wire next_enable    = run_like || (cdelay_n && !early_disable);
   wire next_inhibit   = (next_state == mdss_pkg::ST_RUN) && at_standstill;

   // Other limits win while active, else programmed limit in fast stop
   wire [mdss_pkg::CUR_W-1:0] next_limit =
      other_i_limit_active ? other_i_limit : prog_stop_i_limit;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         speed_demand        <= mdss_pkg::SPEED_ZERO;
         current_limit       <= '0;
         current_limit_valid <= 1'b0;
         contactor_on        <= 1'b0;
         drive_enable        <= 1'b0;
         controller_inhibit  <= 1'b0;
         run_indicator       <= 1'b0;
         prog_stop_active    <= 1'b0;
      end else begin
         speed_demand        <= ramp_demand;
         current_limit       <= next_limit;
         current_limit_valid <= pstop_n || other_i_limit_active;
         contactor_on        <= next_contactor;
         drive_enable        <= next_enable;
         controller_inhibit  <= next_inhibit;
         run_indicator       <= run_like;
         prog_stop_active    <= pstop_n;
      end
   end
endmodule

// ### verification/mdss_motor_model.sv
// Motor model: speed feedback follows demand, or a load speed that spins it
module mdss_motor_model (
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   input  wire logic [mdss_pkg::SPEED_W-1:0] speed_demand,
   input  wire logic [mdss_pkg::SPEED_W-1:0] load_speed,
   output logic      [mdss_pkg::SPEED_W-1:0] speed_feedback
);
   timeunit 1ns;
   timeprecision 1ps;
   // Shaft speed is the larger of demand and what the load imposes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         speed_feedback <= 16'h0000;
      end else begin
         speed_feedback <= (speed_demand > load_speed) ? speed_demand : load_speed;
      end
   end
endmodule

// ### verification/mdss_monitor.sv
// Checker of the stop sequencer outputs
module mdss_monitor (
   input wire logic                         ref_clk,
   input wire logic                         rst,
   input wire logic                         run_input_terminal,
   input wire logic                         fast_stop_terminal,
   input wire logic                         regen_variant,
   input wire logic [mdss_pkg::SPEED_W-1:0] coast_step,
   input wire logic [mdss_pkg::CUR_W-1:0]   prog_stop_i_limit,
   input wire logic [mdss_pkg::CUR_W-1:0]   other_i_limit,
   input wire logic                         other_i_limit_active,
   input wire logic [mdss_pkg::SPEED_W-1:0] speed_demand,
   input wire logic [mdss_pkg::CUR_W-1:0]   current_limit,
   input wire logic                         current_limit_valid,
   input wire logic                         contactor_on,
   input wire logic                         drive_enable,
   input wire logic                         controller_inhibit,
   input wire logic                         run_indicator,
   input wire logic                         prog_stop_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // Sequences of terminal activity
   // ------------------------------------------------------------
   sequence s_fast_low;
      (!fast_stop_terminal) [*4];
   endsequence
   sequence s_idle_off;
      (!contactor_on && !run_input_terminal) [*2];
   endsequence
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   a_inhibit_keeps_on: assert property (controller_inhibit |-> contactor_on && run_indicator)
      else $error("inhibit without contactor or run indicator");
   a_drive_needs_contactor: assert property (drive_enable |-> contactor_on)
      else $error("drive enabled with contactor off");
   a_prog_limit_passed: assert property (prog_stop_active && $past(prog_stop_active)
      && !$past(other_i_limit_active) |-> current_limit_valid
      && current_limit == $past(prog_stop_i_limit))
      else $error("programmed stop limit not passed on");
   a_other_limit_wins: assert property ($past(other_i_limit_active) && current_limit_valid
      |-> current_limit == $past(other_i_limit))
      else $error("other current limit not given precedence");
   a_prog_ramp_down: assert property (prog_stop_active && $past(prog_stop_active)
      |-> speed_demand <= $past(speed_demand))
      else $error("demand rose during programmed stop");
   a_coast_step_cap: assert property (!run_input_terminal && !$past(run_input_terminal)
      && !prog_stop_active && !$past(prog_stop_active) && !regen_variant
      && !$past(regen_variant) && speed_demand <= $past(speed_demand)
      |-> ($past(speed_demand) - speed_demand) <= $past(coast_step, 2))
      else $error("non-regenerative stop faster than coast rate");
   a_fast_stop_wins: assert property (s_fast_low ##0 contactor_on |-> prog_stop_active)
      else $error("fast stop terminal low without programmed stop");
   a_off_holds: assert property (s_idle_off |=> !contactor_on)
      else $error("contactor on with run terminal low");
endmodule
bind mdss_top mdss_monitor i_mdss_monitor (
   .ref_clk(ref_clk), .rst(rst), .run_input_terminal(run_input_terminal),
   .fast_stop_terminal(fast_stop_terminal), .regen_variant(regen_variant),
   .coast_step(coast_step), .prog_stop_i_limit(prog_stop_i_limit),
   .other_i_limit(other_i_limit), .other_i_limit_active(other_i_limit_active),
   .speed_demand(speed_demand), .current_limit(current_limit),
   .current_limit_valid(current_limit_valid), .contactor_on(contactor_on),
   .drive_enable(drive_enable), .controller_inhibit(controller_inhibit),
   .run_indicator(run_indicator), .prog_stop_active(prog_stop_active));

// ### verification/test_motor_drive_stop_sequencer.sv
// Testbench of the motor drive stop sequencer
module test_motor_drive_stop_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0, rst = 1'b1, run = 1'b1, ovr = 1'b0, fast = 1'b1;
   logic [15:0] szs = 16'h0000, slim = 16'h0064, load = 16'h0000;
   logic        oth_act = 1'b0, regen = 1'b0;
   logic [15:0] sp = 16'h0000, stime = 16'h0000, cdly = 16'h0001, coast = 16'h2000;
   logic [15:0] demand, fb, cur_lim;
   logic        cur_vld, cont, drv, inh, run_ind, pstop;
   int          n_errors = 0, check_count = 0;
   always #5 ref_clk = ~ref_clk;
   mdss_top i_mdss_top (.ref_clk(ref_clk), .rst(rst), .run_input_terminal(run),
      .delay_override_terminal(ovr), .fast_stop_terminal(fast), .regen_variant(regen),
      .speed_setpoint(sp), .speed_feedback(fb), .zero_threshold(16'h0100),
      .stop_zero_speed(szs), .stop_time_ms(stime), .stop_limit_ms(slim),
      .contactor_delay_ms(cdly), .prog_stop_time_ms(16'h0000),
      .prog_stop_limit_ms(16'h0064), .coast_step(coast),
      .prog_stop_i_limit(16'h1234), .other_i_limit(16'h0abc),
      .other_i_limit_active(oth_act), .speed_demand(demand), .current_limit(cur_lim),
      .current_limit_valid(cur_vld), .contactor_on(cont), .drive_enable(drv),
      .controller_inhibit(inh), .run_indicator(run_ind), .prog_stop_active(pstop));
   mdss_motor_model i_mdss_motor_model (.ref_clk(ref_clk), .rst(rst),
      .speed_demand(demand), .load_speed(load), .speed_feedback(fb));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wait_off(input int lim);
      int i;
      i = 0;
      while (cont !== 1'b0 && i < lim) begin
         cyc(1);
         i++;
      end
   endtask
   task automatic wait_move(input logic [15:0] from, input int lim);
      int i;
      i = 0;
      while (demand === from && i < lim) begin
         cyc(1);
         i++;
      end
   endtask
   task automatic print_verdict;
      if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_standstill;
      cyc(6);
      check(inh, 1'b1);
      check({cont, run_ind}, 2'b11);
      load = 16'h4000;
      cyc(6);
      check(inh, 1'b0);
      load = 16'h0000;
      cyc(6);
   endtask
   task automatic test_stop_skip_delay;
      run = 1'b0;
      cyc(8);
      check({cont, drv}, 2'b00);
      run = 1'b1;
      cyc(6);
      check({cont, drv}, 2'b11);
   endtask
   task automatic test_contactor_delay;
      ovr = 1'b1;
      szs = 16'h0200;
      run = 1'b0;
      cyc(8);
      check({cont, drv}, 2'b10);
      wait_off(110000);
      check({cont, drv}, 2'b00);
      run = 1'b1;
      ovr = 1'b0;
      szs = 16'h0000;
      cyc(6);
   endtask
   task automatic test_ramp_rates;
      sp = 16'h4000;
      cyc(6);
      check(demand, 16'h4000);
      run = 1'b0;
      wait_move(16'h4000, 110000);
      check(demand, 16'h2000);
      wait_off(220000);
      check(demand, 16'h0000);
      run = 1'b1;
      regen = 1'b1;
      stime = 16'h0002;
      cyc(6);
      run = 1'b0;
      wait_move(16'h4000, 110000);
      check(demand, 16'h0000);
      wait_off(110000);
      run = 1'b1;
      regen = 1'b0;
      stime = 16'h0000;
      sp = 16'h0000;
      cyc(6);
   endtask
   task automatic test_prog_stop;
      load = 16'h4000;
      cyc(6);
      fast = 1'b0;
      cyc(6);
      check({pstop, cont, cur_vld}, 3'b111);
      check(cur_lim, 16'h1234);
      oth_act = 1'b1;
      cyc(4);
      check(cur_lim, 16'h0abc);
      oth_act = 1'b0;
      load = 16'h0000;
      cyc(8);
      check({pstop, cont, drv}, 3'b000);
      fast = 1'b1;
      cyc(6);
   endtask
   task automatic test_switch_and_limit;
      load = 16'h4000;
      run = 1'b0;
      cyc(6);
      fast = 1'b0;
      cyc(6);
      check(pstop, 1'b1);
      load = 16'h0000;
      cyc(8);
      fast = 1'b1;
      run = 1'b1;
      load = 16'h4000;
      slim = 16'h0001;
      cyc(6);
      run = 1'b0;
      wait_off(110000);
      check({cont, drv}, 2'b00);
   endtask
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      cyc(8);
      rst = 1'b0;
      test_standstill();
      test_stop_skip_delay();
      test_contactor_delay();
      test_ramp_rates();
      test_prog_stop();
      test_switch_and_limit();
      print_verdict();
   end
   initial begin
      #8_000_000;
      n_errors++;
      print_verdict();
   end
endmodule
